// *** bench/bdb_loader_model.sv ***
`timescale 1ns/100ps
// loader stand-in: answers each request after i_delay cycles (at least 1)
module bdb_loader_model
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // request and behaviour
  input wire logic i_req,
  input wire logic i_fail_mode,
  input wire logic i_ext_sel,
  input wire logic [7:0] i_delay,
  // answer
  output logic o_done,
  output logic o_fail,
  output logic o_ext_switch
);
  logic [7:0] cnt_q;
  always @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      cnt_q <= 8'h00;
      o_done <= 1'b0;
      o_fail <= 1'b0;
      o_ext_switch <= 1'b0;
    end
    else
    begin
      o_done <= (cnt_q == 8'h01) && !i_fail_mode;
      o_fail <= (cnt_q == 8'h01) && i_fail_mode;
      // only meaningful with done; toggles otherwise so stale values show
      o_ext_switch <= (cnt_q == 8'h01) ? i_ext_sel : ~o_ext_switch;
      if (i_req)
        cnt_q <= i_delay;
      else if (cnt_q != 8'h00)
        cnt_q <= cnt_q - 8'h01;
    end
  end
endmodule

// *** bench/boot_dead_battery_power_states_test.sv ***
`timescale 1ns/100ps
module boot_dead_battery_power_states_test;
  import bdb_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  bdb_policy_type pol = no_response_policy;
  bdb_dflt_type dflt = dflt_safe;
  logic main_in = 1'b0;
  logic fm = 1'b1;
  logic pd = 1'b0;
  logic i2c = 1'b0;
  logic idle_rq = 1'b0;
  logic sleep_rq = 1'b0;
  logic [1:0] vb = 2'h0;
  logic [1:0] conn = 2'h0;
  logic [7:0] dly = 8'h02;
  logic req, done, fail, ext, bdone, bwait, ext_pin, ports, sonly, legacy, ufp, alt;
  logic osc, pde, spie, i2ce, drop, dact, tdet;
  logic xs = 1'b0;
  logic [1:0] sw, pst, csel;
  logic [2:0] adflt;
  logic [15:0] cap [6];
  int n_fail = 0;
  int checked = 0;
  int n_req = 0;
  int cyc = 0;
  int tn = 0;

  always #20 clk = ~clk;

  bdb_loader_model u_bdb_loader_model (.i_sys_clk(clk), .i_rst_b(rst_b), .i_req(req),
    .i_fail_mode(fm), .i_ext_sel(xs), .i_delay(dly), .o_done(done), .o_fail(fail),
    .o_ext_switch(ext));

  bdb_sequencer u_bdb_sequencer (.i_sys_clk(clk), .i_rst_b(rst_b), .i_db_policy(pol),
    .i_default_cfg(dflt), .i_main_supply_input(main_in), .i_vbus_present(vb),
    .i_cfg_load_done(done), .i_cfg_load_fail(fail), .i_cfg_ext_switch(ext),
    .i_port_connected(conn), .i_pd_msg(pd), .i_i2c_activity(i2c), .i_idle_req(idle_rq),
    .i_sleep_req(sleep_rq), .o_cfg_load_req(req), .o_boot_done(bdone),
    .o_boot_waiting(bwait), .o_default_active(dact), .o_active_default(adflt),
    .o_int_switch_en(sw), .o_external_sink_control_pin(ext_pin), .o_ports_enabled(ports),
    .o_sink_only(sonly), .o_legacy_sink(legacy), .o_ufp_only(ufp), .o_altmode_en(alt),
    .o_sink_min_mv(cap[0]), .o_sink_max_mv(cap[1]), .o_sink_min_ma(cap[2]),
    .o_sink_max_ma(cap[3]), .o_src_mv(cap[4]), .o_src_ma(cap[5]), .o_power_state(pst),
    .o_core_clk_sel(csel), .o_osc24_en(osc), .o_pd_enable(pde), .o_spi_enable(spie),
    .o_i2c_enable(i2ce), .o_typec_detect_en(tdet), .o_pd_msg_drop(drop));

  task automatic test_done;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // counts a hang as a failure; runs need far fewer cycles
  always @(posedge clk)
  begin
    cyc++;
    if (req === 1'b1)
      n_req++;
    if (cyc == 20000)
    begin
      n_fail++;
      test_done;
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic endt;
    tn++;
    $display("test %0d done", tn);
  endtask

  // straps and pins held stable from reset release onwards
  task automatic boot(input bdb_policy_type p, input bdb_dflt_type d, input logic m,
    input logic [1:0] v, input logic f, input logic [7:0] dl, input int n);
    cycles(1);
    rst_b = 1'b0;
    pol = p;
    dflt = d;
    main_in = m;
    vb = v;
    fm = f;
    dly = dl;
    conn = 2'h0;
    idle_rq = 1'b0;
    sleep_rq = 1'b0;
    cycles(2);
    n_req = 0;
    rst_b = 1'b1;
    cycles(n);
  endtask

  initial
  begin
    boot(no_response_policy, dflt_cfg_three, 1'b1, 2'h0, 1'b1, 8'h02, 40);
    check(bdone, 1);
    check(ufp, 1);
    check(alt, 0);
    check(ports, 1);
    check(sonly, 0);
    foreach (cap[i])
      check(cap[i], i == 0 ? SINK_MIN_MV : i == 1 ? SINK_MAX_MV : i == 2 ? SINK_MIN_MA :
        i == 3 ? SINK_MAX_MA : CAP_NONE);
    check({dact, adflt, tdet}, {1'b1, dflt_cfg_three, 1'b1});
    endt;
    idle_rq = 1'b1;
    cycles(2);
    check(pst, ps_idle);
    check(csel, CLK_SEL_IDLE);
    check({osc, pde, spie, i2ce}, 4'h9);
    idle_rq = 1'b0;
    pd = 1'b1;
    cycles(1);
    pd = 1'b0;
    check({pst, drop}, 3'h1);
    sleep_rq = 1'b1;
    cycles(2);
    check({pst, csel, osc, i2ce, tdet}, 7'h71);
    pd = 1'b1;
    cycles(1);
    pd = 1'b0;
    cycles(1);
    check(pst, ps_sleep);
    i2c = 1'b1;
    sleep_rq = 1'b0;
    cycles(1);
    i2c = 1'b0;
    check(pst, ps_active);
    sleep_rq = 1'b1;
    cycles(2);
    conn = 2'h1;
    sleep_rq = 1'b0;
    cycles(1);
    check(pst, ps_active);
    sleep_rq = 1'b1;
    cycles(3);
    check(pst, ps_active);
    endt;
    boot(no_response_policy, dflt_safe, 1'b0, 2'h1, 1'b1, 8'h02, 40);
    check({bdone, sw, ext_pin, n_req != 0}, 5'h00);
    endt;
    boot(wait_supply_internal_switch, dflt_safe, 1'b0, 2'h1, 1'b1, 8'h02, 40);
    check({bdone, sw, n_req != 0}, 4'h2);
    main_in = 1'b1;
    cycles(20);
    check(n_req != 0, 1);
    endt;
    boot(controller_wait_external_switch, dflt_safe, 1'b0, 2'h1, 1'b1, 8'h02, 60);
    check({bdone, ext_pin, sw, n_req > 2}, 5'h09);
    endt;
    boot(continue_boot_policy, dflt_safe, 1'b0, 2'h1, 1'b1, 8'h02, 40);
    check(bdone, 1);
    check({legacy, ports}, 2'h2);
    check(sonly, 1);
    endt;
    boot(continue_boot_policy, dflt_cfg_five, 1'b0, 2'h1, 1'b1, 8'h02, 40);
    check({ext_pin, ufp, alt}, 3'h6);
    check(cap[4], CAP_NONE);
    endt;
    boot(continue_boot_policy, dflt_safe, 1'b0, 2'h1, 1'b0, 8'h1e, 20);
    check({sw, n_req != 0}, 3'h1);
    cycles(30);
    check({bdone, sw}, 3'h5);
    check(dact, 0);
    endt;
    xs = 1'b1;
    boot(continue_boot_policy, dflt_safe, 1'b0, 2'h1, 1'b0, 8'h02, 40);
    check({bdone, ext_pin, sw, dact}, 5'h18);
    xs = 1'b0;
    endt;
    boot(no_response_policy, dflt_inf_wait, 1'b1, 2'h0, 1'b1, 8'h02, 40);
    check({bwait, bdone}, 2'h2);
    endt;
    test_done;
  end
endmodule

// *** logic/bdb_pkg.sv ***
package bdb_pkg;

  // dead-battery policy, as decoded from the boot straps
  typedef enum logic [2:0]
  {
    no_response_policy = 3'h0,
    wait_supply_internal_switch = 3'h1,
    wait_supply_external_switch = 3'h2,
    controller_wait_internal_switch = 3'h3,
    controller_wait_external_switch = 3'h4,
    continue_boot_policy = 3'h5
  } bdb_policy_type;

  // behaviour when no configuration bundle can be loaded
  typedef enum logic [2:0]
  {
    dflt_safe = 3'h0,
    dflt_inf_wait = 3'h1,
    dflt_reserved = 3'h2,
    dflt_cfg_three = 3'h3,
    dflt_cfg_five = 3'h5
  } bdb_dflt_type;

  // boot sequence, gray along strap -> load -> wait -> run
  typedef enum logic [2:0]
  {
    bt_strap = 3'h0,
    bt_load = 3'h1,
    bt_wait_load = 3'h3,
    bt_run = 3'h2,
    bt_supply_wait = 3'h4,
    bt_inf_wait = 3'h7
  } bdb_boot_type;

  typedef enum logic [1:0]
  {
    ps_active = 2'h0,
    ps_idle = 2'h1,
    ps_sleep = 2'h3
  } bdb_pwr_type;

  // core clock select: 12 MHz, 4 to 6 MHz, 100 kHz
  localparam logic [1:0] CLK_SEL_12M = 2'h0;
  localparam logic [1:0] CLK_SEL_IDLE = 2'h1;
  localparam logic [1:0] CLK_SEL_100K = 2'h2;

  // cycles after reset release before straps and supplies are trusted
  localparam logic [2:0] SETTLE_CYCLES = 3'h5;

  // advertised capabilities of the built-in defaults, mV and mA
  localparam logic [15:0] SINK_MIN_MV = 16'h1388;
  localparam logic [15:0] SINK_MAX_MV = 16'h4e20;
  localparam logic [15:0] SINK_MIN_MA = 16'h0384;
  localparam logic [15:0] SINK_MAX_MA = 16'h0bb8;
  localparam logic [15:0] SRC_MV = 16'h1388;
  localparam logic [15:0] SRC_MA = 16'h0bb8;
  localparam logic [15:0] CAP_NONE = 16'h0000;

  localparam int unsigned PORT_COUNT = 2;

endpackage

// *** logic/bdb_sequencer.sv ***
`timescale 1ns/100ps
// Contract
// [RULE_01] strapped dead-battery policy acts only when running from bus power
// [RULE_02] no-response policy: no switch, no start-up until main supply present
// [RULE_03] wait-for-supply: close bus path switch, hold boot until main supply
// [RULE_04] controller-wait: close bus path switch, retry configuration load forever
// [RULE_05] continue-boot policy keeps booting and loads configuration on bus power
// [RULE_06] continue-boot: close switch only after load, chosen by loaded config
// [RULE_07] board uses external sink pin or first high-voltage path as sink
// [RULE_08] every power-up tries to load configuration over SPI or I2C
// [RULE_09] no config and safe default: ports off, legacy sink on bus power
// [RULE_10] no config and infinite-wait default: stay in boot waiting for config
// [RULE_11] default three: upstream only, internal switch, 5-20 V 0.9-3 A sink
// [RULE_12] default five: upstream only, external switch, sink plus 5 V 3 A source
// [RULE_13] one of Active, Idle, Sleep; Sleep only with both ports unconnected
// [RULE_14] core clock 12 MHz, 4-6 MHz, 100 kHz; 24 MHz oscillator off only asleep
// [RULE_15] PD message wakes from Idle but not from Sleep
// [RULE_16] first PD message after Idle wake may be discarded
// [RULE_17] I2C traffic and attach or detach wake from Idle and Sleep
// [RULE_18] regulator fed from bus power: ports operate only as sinks
// [RULE_19] I2C host interface; boot bundle accepted over I2C or SPI
// [RULE_20] PD and SPI only Active, I2C Active and Idle, detection always
module bdb_sequencer
  import bdb_pkg::*;
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // decoded boot straps
  input wire bdb_pkg::bdb_policy_type i_db_policy,
  input wire bdb_pkg::bdb_dflt_type i_default_cfg,
  // supply pins
  input wire logic i_main_supply_input,
  input wire logic [bdb_pkg::PORT_COUNT-1:0] i_vbus_present,
  // configuration loader
  input wire logic i_cfg_load_done,
  input wire logic i_cfg_load_fail,
  input wire logic i_cfg_ext_switch,
  // type-c and traffic events
  input wire logic [bdb_pkg::PORT_COUNT-1:0] i_port_connected,
  input wire logic i_pd_msg,
  input wire logic i_i2c_activity,
  // firmware power requests
  input wire logic i_idle_req,
  input wire logic i_sleep_req,
  // boot status and loader control
  output logic o_cfg_load_req,
  output logic o_boot_done,
  output logic o_boot_waiting,
  output logic o_default_active,
  output logic [2:0] o_active_default,
  // power path control
  output logic [bdb_pkg::PORT_COUNT-1:0] o_int_switch_en,
  output logic o_external_sink_control_pin,
  output logic o_ports_enabled,
  output logic o_sink_only,
  output logic o_legacy_sink,
  output logic o_ufp_only,
  output logic o_altmode_en,
  // advertised capabilities
  output logic [15:0] o_sink_min_mv,
  output logic [15:0] o_sink_max_mv,
  output logic [15:0] o_sink_min_ma,
  output logic [15:0] o_sink_max_ma,
  output logic [15:0] o_src_mv,
  output logic [15:0] o_src_ma,
  // power state
  output logic [1:0] o_power_state,
  output logic [1:0] o_core_clk_sel,
  output logic o_osc24_en,
  output logic o_pd_enable,
  output logic o_spi_enable,
  output logic o_i2c_enable,
  output logic o_typec_detect_en,
  output logic o_pd_msg_drop
);

  import bdb_pkg::*;

  logic main_s;
  logic [PORT_COUNT-1:0] vbus_s;
  logic bus_powered;

  bdb_sync #(.WIDTH(1 + PORT_COUNT)) u_sync
  (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_pin({i_main_supply_input, i_vbus_present}),
    .o_level({main_s, vbus_s})
  );

  // running at all but without main supply means the bus feeds the regulator
  assign bus_powered = !main_s;

  function automatic logic is_ext_policy(input bdb_policy_type p);
    is_ext_policy = (p == wait_supply_external_switch) ||
      (p == controller_wait_external_switch);
  endfunction

  function automatic logic [PORT_COUNT-1:0] port_mask(input logic [PORT_COUNT-1:0] v);
    // only one sink path; port zero wins if both see bus power
    port_mask = v[0] ? 2'h1 : (v[1] ? 2'h2 : 2'h0);
  endfunction

  // boot group
  bdb_boot_type boot_q, boot_d;
  bdb_policy_type policy_q, policy_d;
  bdb_dflt_type dflt_q, dflt_d;
  logic [2:0] settle_q, settle_d;
  logic db_applied_q, db_applied_d;
  logic req_q, req_d;
  logic dflt_act_q, dflt_act_d;
  logic ports_q, ports_d;
  logic legacy_q, legacy_d;
  logic ufp_q, ufp_d;
  logic alt_q, alt_d;
  logic ext_q, ext_d;
  logic [PORT_COUNT-1:0] sw_q, sw_d;
  logic [15:0] snk_lo_mv_q, snk_lo_mv_d, snk_hi_mv_q, snk_hi_mv_d;
  logic [15:0] snk_lo_ma_q, snk_lo_ma_d, snk_hi_ma_q, snk_hi_ma_d;
  logic [15:0] src_mv_q, src_mv_d, src_ma_q, src_ma_d;
  logic sink_only_q, sink_only_d;
  logic run_q, run_d;
  logic waiting_q, waiting_d;
  logic [15:0] src_out_mv_q, src_out_mv_d, src_out_ma_q, src_out_ma_d;

  always_comb
  begin
    boot_d = boot_q;
    policy_d = policy_q;
    dflt_d = dflt_q;
    settle_d = settle_q;
    db_applied_d = db_applied_q;
    req_d = 1'b0;
    dflt_act_d = dflt_act_q;
    ports_d = ports_q;
    legacy_d = legacy_q;
    ufp_d = ufp_q;
    alt_d = alt_q;
    ext_d = ext_q;
    sw_d = sw_q;
    snk_lo_mv_d = snk_lo_mv_q;
    snk_hi_mv_d = snk_hi_mv_q;
    snk_lo_ma_d = snk_lo_ma_q;
    snk_hi_ma_d = snk_hi_ma_q;
    src_mv_d = src_mv_q;
    src_ma_d = src_ma_q;
    sink_only_d = bus_powered; // [RULE_18]
    case (boot_q)
      bt_strap:
      begin
        // straps are caught after release, once the synchroniser has filled
        if (settle_q != SETTLE_CYCLES)
        begin
          settle_d = settle_q + 3'h1;
        end
        else
        begin
          policy_d = i_db_policy;
          dflt_d = i_default_cfg;
          db_applied_d = bus_powered; // [RULE_01]
          if (!bus_powered)
          begin
            boot_d = bt_load; // [RULE_08]
          end
          else
          begin
            case (i_db_policy)
              wait_supply_internal_switch, wait_supply_external_switch:
              begin
                boot_d = bt_supply_wait; // [RULE_03]
                if (is_ext_policy(i_db_policy))
                begin
                  ext_d = 1'b1; // [RULE_07]
                end
                else
                begin
                  sw_d = port_mask(vbus_s); // [RULE_03]
                end
              end
              controller_wait_internal_switch, controller_wait_external_switch:
              begin
                boot_d = bt_load; // [RULE_04]
                if (is_ext_policy(i_db_policy))
                begin
                  ext_d = 1'b1; // [RULE_07]
                end
                else
                begin
                  sw_d = port_mask(vbus_s); // [RULE_04]
                end
              end
              continue_boot_policy:
              begin
                boot_d = bt_load; // [RULE_05]
              end
              default:
              begin
                boot_d = bt_supply_wait; // [RULE_02]
              end
            endcase
          end
        end
      end
      bt_supply_wait:
      begin
        if (main_s)
        begin
          boot_d = bt_load; // [RULE_03]
        end
      end
      bt_load:
      begin
        req_d = 1'b1; // [RULE_08]
        boot_d = bt_wait_load;
      end
      bt_wait_load, bt_inf_wait:
      begin
        // a bundle may still arrive from the I2C host while waiting forever
        if (i_cfg_load_done)
        begin
          boot_d = bt_run; // [RULE_19]
          ports_d = 1'b1;
          alt_d = 1'b1;
          dflt_act_d = 1'b0;
          if (db_applied_q && policy_q == continue_boot_policy)
          begin
            if (i_cfg_ext_switch)
            begin
              ext_d = 1'b1; // [RULE_06]
            end
            else
            begin
              sw_d = port_mask(vbus_s); // [RULE_06]
            end
          end
        end
        else if (i_cfg_load_fail && boot_q == bt_wait_load)
        begin
          if (db_applied_q && (policy_q == controller_wait_internal_switch ||
              policy_q == controller_wait_external_switch))
          begin
            boot_d = bt_load; // [RULE_04]
          end
          else
          begin
            case (dflt_q)
              dflt_inf_wait:
              begin
                boot_d = bt_inf_wait; // [RULE_10]
              end
              dflt_cfg_three:
              begin
                boot_d = bt_run;
                dflt_act_d = 1'b1;
                ports_d = 1'b1;
                ufp_d = 1'b1; // [RULE_11]
                alt_d = 1'b0;
                snk_lo_mv_d = SINK_MIN_MV;
                snk_hi_mv_d = SINK_MAX_MV;
                snk_lo_ma_d = SINK_MIN_MA;
                snk_hi_ma_d = SINK_MAX_MA;
                if (bus_powered)
                begin
                  sw_d = port_mask(vbus_s); // [RULE_11]
                end
              end
              dflt_cfg_five:
              begin
                boot_d = bt_run;
                dflt_act_d = 1'b1;
                ports_d = 1'b1;
                ufp_d = 1'b1; // [RULE_12]
                alt_d = 1'b0;
                snk_lo_mv_d = SINK_MIN_MV;
                snk_hi_mv_d = SINK_MAX_MV;
                snk_lo_ma_d = SINK_MIN_MA;
                snk_hi_ma_d = SINK_MAX_MA;
                src_mv_d = SRC_MV;
                src_ma_d = SRC_MA;
                ext_d = bus_powered; // [RULE_12]
              end
              default:
              begin
                // reserved codes fall back to the safe default
                boot_d = bt_run;
                dflt_act_d = 1'b1;
                ports_d = 1'b0; // [RULE_09]
                legacy_d = bus_powered; // [RULE_09]
              end
            endcase
          end
        end
      end
      default:
      begin
        boot_d = boot_q;
      end
    endcase
    run_d = (boot_d == bt_run);
    waiting_d = (boot_d == bt_inf_wait);
    // masked before the flop so the source pins carry no mux
    src_out_mv_d = sink_only_d ? CAP_NONE : src_mv_d; // [RULE_18]
    src_out_ma_d = sink_only_d ? CAP_NONE : src_ma_d; // [RULE_18]
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      boot_q <= bt_strap;
      policy_q <= no_response_policy;
      dflt_q <= dflt_safe;
      settle_q <= 3'h0;
      db_applied_q <= 1'b0;
      req_q <= 1'b0;
      dflt_act_q <= 1'b0;
      ports_q <= 1'b0;
      legacy_q <= 1'b0;
      ufp_q <= 1'b0;
      alt_q <= 1'b0;
      ext_q <= 1'b0;
      sw_q <= '0;
      snk_lo_mv_q <= CAP_NONE;
      snk_hi_mv_q <= CAP_NONE;
      snk_lo_ma_q <= CAP_NONE;
      snk_hi_ma_q <= CAP_NONE;
      src_mv_q <= CAP_NONE;
      src_ma_q <= CAP_NONE;
      sink_only_q <= 1'b0;
      run_q <= 1'b0;
      waiting_q <= 1'b0;
      src_out_mv_q <= CAP_NONE;
      src_out_ma_q <= CAP_NONE;
    end
    else
    begin
      boot_q <= boot_d;
      policy_q <= policy_d;
      dflt_q <= dflt_d;
      settle_q <= settle_d;
      db_applied_q <= db_applied_d;
      req_q <= req_d;
      dflt_act_q <= dflt_act_d;
      ports_q <= ports_d;
      legacy_q <= legacy_d;
      ufp_q <= ufp_d;
      alt_q <= alt_d;
      ext_q <= ext_d;
      sw_q <= sw_d;
      snk_lo_mv_q <= snk_lo_mv_d;
      snk_hi_mv_q <= snk_hi_mv_d;
      snk_lo_ma_q <= snk_lo_ma_d;
      snk_hi_ma_q <= snk_hi_ma_d;
      src_mv_q <= src_mv_d;
      src_ma_q <= src_ma_d;
      sink_only_q <= sink_only_d;
      run_q <= run_d;
      waiting_q <= waiting_d;
      src_out_mv_q <= src_out_mv_d;
      src_out_ma_q <= src_out_ma_d;
    end
  end

  // power-state group
  bdb_pwr_type pwr_q, pwr_d;
  logic [PORT_COUNT-1:0] conn_q;
  logic attach_evt;
  logic any_conn;
  logic drop_q, drop_d;
  logic [1:0] clk_sel_q, clk_sel_d;
  logic osc_q, osc_d;
  logic fast_q, fast_d;
  logic i2ce_q, i2ce_d;
  logic detect_q;

  assign attach_evt = (conn_q != i_port_connected);
  assign any_conn = |i_port_connected;

  always_comb
  begin
    pwr_d = pwr_q;
    drop_d = 1'b0;
    case (pwr_q)
      ps_active:
      begin
        if (boot_q == bt_run && i_sleep_req && !any_conn)
        begin
          pwr_d = ps_sleep; // [RULE_13]
        end
        else if (boot_q == bt_run && i_idle_req)
        begin
          pwr_d = ps_idle;
        end
      end
      ps_idle:
      begin
        if (i_i2c_activity || attach_evt)
        begin
          pwr_d = ps_active; // [RULE_17]
        end
        else if (i_pd_msg)
        begin
          pwr_d = ps_active; // [RULE_15]
          drop_d = 1'b1; // [RULE_16]
        end
        else if (i_sleep_req && !any_conn)
        begin
          pwr_d = ps_sleep; // [RULE_13]
        end
      end
      ps_sleep:
      begin
        // pd traffic is not seen here: the receiver runs on the 24 MHz clock
        if (i_i2c_activity || attach_evt || any_conn)
        begin
          pwr_d = ps_active; // [RULE_17]
        end
      end
      default:
      begin
        pwr_d = ps_active;
      end
    endcase
    clk_sel_d = (pwr_d == ps_active) ? CLK_SEL_12M :
      ((pwr_d == ps_idle) ? CLK_SEL_IDLE : CLK_SEL_100K); // [RULE_14]
    osc_d = (pwr_d != ps_sleep); // [RULE_14]
    fast_d = (pwr_d == ps_active); // [RULE_20]
    i2ce_d = (pwr_d != ps_sleep); // [RULE_20]
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      pwr_q <= ps_active;
      conn_q <= '0;
      drop_q <= 1'b0;
      clk_sel_q <= CLK_SEL_12M;
      osc_q <= 1'b1;
      fast_q <= 1'b1;
      i2ce_q <= 1'b1;
      detect_q <= 1'b1;
    end
    else
    begin
      pwr_q <= pwr_d;
      conn_q <= i_port_connected;
      drop_q <= drop_d;
      clk_sel_q <= clk_sel_d;
      osc_q <= osc_d;
      fast_q <= fast_d;
      i2ce_q <= i2ce_d;
      // detection runs in every power state
      detect_q <= 1'b1; // [RULE_20]
    end
  end

  assign o_cfg_load_req = req_q;
  assign o_boot_done = run_q;
  assign o_boot_waiting = waiting_q;
  assign o_default_active = dflt_act_q;
  assign o_active_default = dflt_q;
  assign o_int_switch_en = sw_q;
  assign o_external_sink_control_pin = ext_q;
  assign o_ports_enabled = ports_q;
  assign o_sink_only = sink_only_q;
  assign o_legacy_sink = legacy_q;
  assign o_ufp_only = ufp_q;
  assign o_altmode_en = alt_q;
  assign o_sink_min_mv = snk_lo_mv_q;
  assign o_sink_max_mv = snk_hi_mv_q;
  assign o_sink_min_ma = snk_lo_ma_q;
  assign o_sink_max_ma = snk_hi_ma_q;
  assign o_src_mv = src_out_mv_q; // [RULE_18]
  assign o_src_ma = src_out_ma_q; // [RULE_18]
  assign o_power_state = pwr_q;
  assign o_core_clk_sel = clk_sel_q; // [RULE_14]
  assign o_osc24_en = osc_q; // [RULE_14]
  assign o_pd_enable = fast_q; // [RULE_20]
  assign o_spi_enable = fast_q; // [RULE_20]
  assign o_i2c_enable = i2ce_q; // [RULE_20]
  assign o_typec_detect_en = detect_q; // [RULE_20]
  assign o_pd_msg_drop = drop_q;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  sequence seq_idle_pd;
    pwr_q == ps_idle && i_pd_msg && !i_i2c_activity && !attach_evt;
  endsequence

  sequence seq_woke_dropping;
    pwr_q == ps_active && o_pd_msg_drop;
  endsequence

  chk_sleep_unconnected: assert property // [RULE_13]
    ((pwr_q != ps_sleep) ##1 (pwr_q == ps_sleep) |-> $past(!any_conn))
    else $error("sleep entered with a port connected");
  chk_idle_pd_wake: assert property // [RULE_16]
    (seq_idle_pd |=> seq_woke_dropping ##1 !o_pd_msg_drop)
    else $error("pd message did not wake idle with drop flag");
  chk_sleep_pd_ignored: assert property // [RULE_15]
    (pwr_q == ps_sleep && i_pd_msg && !i_i2c_activity && !attach_evt && !any_conn
      |=> pwr_q == ps_sleep)
    else $error("pd message woke the device from sleep");
  chk_i2c_wake: assert property // [RULE_17]
    (pwr_q != ps_active && i_i2c_activity |=> pwr_q == ps_active ##0 o_i2c_enable)
    else $error("i2c traffic did not wake the device");
  chk_osc_sleep_only: assert property // [RULE_14]
    (!o_osc24_en == (o_core_clk_sel == CLK_SEL_100K && o_power_state == ps_sleep))
    else $error("24 MHz oscillator state does not match sleep");
  chk_supply_hold: assert property // [RULE_03]
    (boot_q == bt_supply_wait && !main_s |=> boot_q == bt_supply_wait && !o_cfg_load_req)
    else $error("boot continued without main supply");
  chk_no_response_off: assert property // [RULE_02]
    (db_applied_q && policy_q == no_response_policy && boot_q == bt_supply_wait
      |-> o_int_switch_en == '0 && !o_external_sink_control_pin)
    else $error("switch closed under no-response policy");
  chk_nowait_switch: assert property // [RULE_06]
    (db_applied_q && policy_q == continue_boot_policy && boot_q != bt_run
      |-> o_int_switch_en == '0 && !o_external_sink_control_pin)
    else $error("switch closed before configuration loaded");
  chk_retry_load: assert property // [RULE_04]
    (boot_q == bt_wait_load && i_cfg_load_fail && !i_cfg_load_done && db_applied_q &&
      (policy_q == controller_wait_internal_switch ||
       policy_q == controller_wait_external_switch)
      |=> boot_q == bt_load ##1 o_cfg_load_req)
    else $error("controller-wait policy did not retry");
  chk_inf_wait_hold: assert property // [RULE_10]
    (boot_q == bt_inf_wait && !i_cfg_load_done |=> boot_q == bt_inf_wait && !o_boot_done)
    else $error("infinite wait left boot without configuration");
  chk_sink_only_src: assert property // [RULE_18]
    (o_sink_only |-> o_src_mv == CAP_NONE && o_src_ma == CAP_NONE)
    else $error("source capability offered on bus power");
  chk_spi_active: assert property // [RULE_20]
    (o_spi_enable || o_pd_enable |-> o_power_state == ps_active)
    else $error("spi or pd enabled outside active");

endmodule

// *** logic/bdb_sync.sv ***
`timescale 1ns/100ps
// three-stage pin synchroniser; output moves only when stages two and three agree
module bdb_sync
#(
  parameter int unsigned WIDTH = 1
)
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // pin side
  input wire logic [WIDTH-1:0] i_pin,
  // synchronised level
  output logic [WIDTH-1:0] o_level
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] mid_q;
  logic [WIDTH-1:0] late_q;
  logic [WIDTH-1:0] level_d;
  logic [WIDTH-1:0] level_q;

  always_comb
  begin
    for (int i = 0; i < WIDTH; i++)
    begin
      level_d[i] = (mid_q[i] == late_q[i]) ? late_q[i] : level_q[i];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      meta_q <= '0;
      mid_q <= '0;
      late_q <= '0;
      level_q <= '0;
    end
    else
    begin
      meta_q <= i_pin;
      mid_q <= meta_q;
      late_q <= mid_q;
      level_q <= level_d;
    end
  end

  assign o_level = level_q;

endmodule
